// ===== rtl/fpet_cfg.svh
// Purpose: Timing counts of the flash program and erase timer
// Assumes: Counts are in timing clock periods
// Notes: Counts are fixed and not configurable
`ifndef FPET_CFG_SVH
`define FPET_CFG_SVH
`define FPET_CNT_W 14
`define FPET_T_WORD 14'h001e
`define FPET_T_BLK_FIRST 14'h0019
`define FPET_T_BLK_NEXT 14'h0012
`define FPET_T_BLK_END 14'h0006
`define FPET_T_MASS 14'h2961
`define FPET_T_SEG 14'h12d3
`define FPET_BLK_LAST 6'h3f
`endif

// ===== rtl/fpet_pkg.sv
// Purpose: Types of the flash program and erase timer
// Assumes: Configuration header included for widths
// Notes: Operation codes and state record
`include "fpet_cfg.svh"
package fpet_pkg;
	typedef enum logic [2:0] {FPET_OP_WORD, FPET_OP_BLOCK, FPET_OP_SEG, FPET_OP_MASS, FPET_OP_NONE} fpet_op_t;
	typedef enum logic [1:0] {FPET_IDLE, FPET_RUN, FPET_WAIT, FPET_END} fpet_state_t;
	typedef struct packed {
		fpet_op_t op;
		logic start;
		logic next_word;
		logic last_word;
	} fpet_req_t;
	typedef struct packed {
		logic [2:0] tick_sync;
		fpet_state_t st;
		fpet_op_t op;
		logic [`FPET_CNT_W-1:0] cnt;
		logic [5:0] pos;
		logic last;
		logic busy;
		logic done;
		logic word_done;
	} fpet_state_rec_t;
endpackage

// ===== rtl/fpet_timer.sv
// Purpose: Times program and erase operations in timing clock periods
// Assumes: i_tg_clk is the timing clock from outside, sampled on i_clk
// Notes: Software must keep the timing clock in band and limit totals
// Functional notes
// - A single word or byte program lasts 30 timing clock periods.
// - The first word of a block program lasts 25 timing clock periods.
// - Each further block word at positions one to sixty-three lasts 18 periods.
// - A finished block program runs a 6 period end sequence before completion.
// - Mass erase lasts 10593 periods and segment erase 4819, both fixed.
`timescale 1ns/1ns
`include "fpet_cfg.svh"
module fpet_timer
	import fpet_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_tg_clk,
	input wire fpet_req_t i_req,
	output logic o_busy,
	output logic o_word_done,
	output logic o_done
);
	fpet_state_rec_t s_q;
	fpet_state_rec_t s_d;
	// Reset release stages, kept apart since they run on the raw reset
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic tick;

	// Start count of one operation kind
	function automatic logic [`FPET_CNT_W-1:0] load_cnt(input fpet_op_t op);
		case (op)
			FPET_OP_WORD: load_cnt = `FPET_T_WORD;
			FPET_OP_BLOCK: load_cnt = `FPET_T_BLK_FIRST;
			FPET_OP_SEG: load_cnt = `FPET_T_SEG;
			FPET_OP_MASS: load_cnt = `FPET_T_MASS;
			default: load_cnt = `FPET_T_WORD;
		endcase
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];
	// Rising timing clock edge, read after two sync stages
	assign tick = s_q.tick_sync[1] & ~s_q.tick_sync[2];

	// Next state of the sequencer
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.word_done = 1'b0;
		if (i_ce) begin
			s_d.tick_sync = {s_q.tick_sync[1:0], i_tg_clk};
			case (s_q.st)
				FPET_IDLE: begin
					if (i_req.start && i_req.op != FPET_OP_NONE) begin
						s_d.st = FPET_RUN;
						s_d.op = i_req.op;
						s_d.cnt = load_cnt(i_req.op);
						s_d.pos = 6'h0;
						s_d.last = i_req.last_word;
						s_d.busy = 1'b1;
					end
				end
				FPET_RUN: begin
					if (tick) begin
						if (s_q.cnt == `FPET_CNT_W'(1)) begin
							if (s_q.op != FPET_OP_BLOCK) begin
								s_d.st = FPET_IDLE;
								s_d.busy = 1'b0;
								s_d.done = 1'b1;
							end else begin
								s_d.word_done = 1'b1;
								if (s_q.last || s_q.pos == `FPET_BLK_LAST) begin
									s_d.st = FPET_END;
									s_d.cnt = `FPET_T_BLK_END;
								end else begin
									s_d.st = FPET_WAIT;
								end
							end
						end else begin
							s_d.cnt = s_q.cnt - `FPET_CNT_W'(1);
						end
					end
				end
				FPET_WAIT: begin
					// Block waits for software to supply the next word
					if (i_req.next_word) begin
						s_d.st = FPET_RUN;
						s_d.pos = s_q.pos + 6'h1;
						s_d.cnt = `FPET_T_BLK_NEXT;
						s_d.last = i_req.last_word;
					end
				end
				FPET_END: begin
					if (tick) begin
						if (s_q.cnt == `FPET_CNT_W'(1)) begin
							s_d.st = FPET_IDLE;
							s_d.busy = 1'b0;
							s_d.done = 1'b1;
						end else begin
							s_d.cnt = s_q.cnt - `FPET_CNT_W'(1);
						end
					end
				end
				default: begin
					s_d.st = FPET_IDLE;
				end
			endcase
		end else begin
			s_d.done = s_q.done;
			s_d.word_done = s_q.word_done;
		end
	end

	// State register, frozen while enable is low
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.tick_sync <= 3'h0;
			s_q.st <= FPET_IDLE;
			s_q.op <= FPET_OP_NONE;
			s_q.cnt <= `FPET_CNT_W'(0);
			s_q.pos <= 6'h0;
			s_q.last <= 1'b0;
			s_q.busy <= 1'b0;
			s_q.done <= 1'b0;
			s_q.word_done <= 1'b0;
		end else begin
			s_q.tick_sync <= s_d.tick_sync;
			s_q.st <= s_d.st;
			s_q.op <= s_d.op;
			s_q.cnt <= s_d.cnt;
			s_q.pos <= s_d.pos;
			s_q.last <= s_d.last;
			s_q.busy <= s_d.busy;
			s_q.done <= s_d.done;
			s_q.word_done <= s_d.word_done;
		end
	end

	assign o_busy = s_q.busy;
	assign o_done = s_q.done;
	assign o_word_done = s_q.word_done;

	// Busy must hold whenever the sequencer is not idle
	busy_tracks_state_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st != FPET_IDLE) == s_q.busy)
		else $error("busy does not match sequencer state");
	// Word program loads a count of 30
	word_count_load_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_IDLE && i_ce && i_req.start && i_req.op == FPET_OP_WORD) |=> s_q.cnt == `FPET_T_WORD)
		else $error("word count not 30");
	// Block first word loads 25
	block_first_load_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_IDLE && i_ce && i_req.start && i_req.op == FPET_OP_BLOCK) |=> s_q.cnt == `FPET_T_BLK_FIRST)
		else $error("block first count not 25");
	// Further block words load 18
	block_next_load_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_WAIT && i_ce && i_req.next_word) |=> (s_q.cnt == `FPET_T_BLK_NEXT && s_q.st == FPET_RUN))
		else $error("block next count not 18");
	// End sequence starts at 6
	end_seq_load_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st != FPET_END) ##1 (s_q.st == FPET_END) |-> s_q.cnt == `FPET_T_BLK_END)
		else $error("end sequence count not 6");
	// Mass erase count is fixed
	erase_count_load_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_IDLE && i_ce && i_req.start && i_req.op == FPET_OP_MASS) |=> s_q.cnt == `FPET_T_MASS)
		else $error("mass erase count not 10593");
	// Completion only ends a busy period
	done_after_busy_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		$rose(s_q.done) |-> !s_q.busy && $past(s_q.busy))
		else $error("done without busy end");
	// A start from idle raises busy on the next cycle
	start_busy_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_IDLE && i_ce && i_req.start && i_req.op != FPET_OP_NONE) |=> s_q.busy)
		else $error("busy not raised after start");
	// Segment erase loads its fixed count
	seg_count_load_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_IDLE && i_ce && i_req.start && i_req.op == FPET_OP_SEG) |=> s_q.cnt == `FPET_T_SEG)
		else $error("segment erase count not 4819");
	// Each counted tick takes one period off the count
	count_step_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st inside {FPET_RUN, FPET_END} && i_ce && tick && s_q.cnt != `FPET_CNT_W'(1))
		|=> s_q.cnt == $past(s_q.cnt) - `FPET_CNT_W'(1))
		else $error("count did not step on tick");
	// Without a tick the count holds
	count_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st inside {FPET_RUN, FPET_END} && i_ce && !tick) |=> $stable(s_q.cnt))
		else $error("count moved without tick");
	// Enable low freezes the whole state record
	ce_freeze_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!i_ce |=> $stable(s_q))
		else $error("state moved while enable low");
	// A word that runs out at the top position goes to the end sequence
	block_top_end_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_RUN && s_q.op == FPET_OP_BLOCK && i_ce && tick && s_q.cnt == `FPET_CNT_W'(1)
		&& s_q.pos == `FPET_BLK_LAST) |=> s_q.st == FPET_END)
		else $error("top block position did not end the block");
	// A word that is not the last waits for the next one with busy high
	block_wait_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_RUN && s_q.op == FPET_OP_BLOCK && i_ce && tick && s_q.cnt == `FPET_CNT_W'(1)
		&& !s_q.last && s_q.pos != `FPET_BLK_LAST) |=> (s_q.st == FPET_WAIT && s_q.busy && s_q.word_done))
		else $error("block word did not wait for next word");
	// The end sequence finishes with completion and busy low
	end_seq_done_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_END && i_ce && tick && s_q.cnt == `FPET_CNT_W'(1))
		|=> (s_q.done && !s_q.busy && s_q.st == FPET_IDLE))
		else $error("end sequence did not complete");
	// Word program and erases finish straight from the count
	op_finish_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st == FPET_RUN && s_q.op != FPET_OP_BLOCK && i_ce && tick && s_q.cnt == `FPET_CNT_W'(1))
		|=> (s_q.done && !s_q.busy))
		else $error("operation did not complete at count end");
	// Word completion only comes from block programming
	word_done_block_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_q.word_done |-> s_q.op == FPET_OP_BLOCK)
		else $error("word completion outside block");
	// Completion stands for one enabled cycle
	done_pulse_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.done && i_ce) |=> !s_q.done)
		else $error("completion longer than one cycle");
	// Word completion stands for one enabled cycle
	word_done_pulse_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.word_done && i_ce) |=> !s_q.word_done)
		else $error("word completion longer than one cycle");
	// A start while busy leaves the running operation alone
	start_refused_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(s_q.st != FPET_IDLE && i_ce && i_req.start) |=> s_q.op == $past(s_q.op))
		else $error("start taken while busy");
endmodule

// ===== tb/fpet_host_model.sv
// Purpose: Host side that supplies the timing clock in bursts
// Assumes: One period is HALF_CLKS cycles high then HALF_CLKS low
// Notes: Clock stands low between bursts so every edge is counted
`timescale 1ns/1ns
module fpet_host_model #(
	parameter int HALF_CLKS = 120
) (
	input wire logic i_clk,
	output logic o_tg_clk
);
	initial o_tg_clk = 1'b0;
	// Emits n rising edges; default period sits inside the band
	task run(input int n);
		repeat (n) begin
			o_tg_clk = 1'b1;
			repeat (HALF_CLKS) @(negedge i_clk);
			o_tg_clk = 1'b0;
			repeat (HALF_CLKS) @(negedge i_clk);
		end
	endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Checks timing counts of program and erase operations
// Assumes: Timing clock runs fast in bursts to keep the run short
// Notes: Inputs change at the falling edge
`timescale 1ns/1ns
module tb_top;
	import fpet_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	fpet_req_t req = '{FPET_OP_NONE, 1'b0, 1'b0, 1'b0};
	logic tg, busy, wd, done;
	int n_errors = 0;
	int compares = 0;
	int n_done = 0;
	int n_wd = 0;
	always #5 clk = ~clk;
	fpet_host_model #(.HALF_CLKS(2)) i_host (.i_clk(clk), .o_tg_clk(tg));
	fpet_timer i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_tg_clk(tg), .i_req(req),
		.o_busy(busy), .o_word_done(wd), .o_done(done));
	// Counts one-cycle pulses, sampled mid-cycle where they are settled
	always @(negedge clk) begin
		if (done === 1'b1) n_done++;
		if (wd === 1'b1) n_wd++;
	end
	task end_of_test();
		$display("n_errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task pulse(input fpet_req_t r);
		@(negedge clk) req = r;
		@(negedge clk) req = '{FPET_OP_NONE, 1'b0, 1'b0, 1'b0};
	endtask
	task settle();
		repeat (8) @(negedge clk);
	endtask
	// Start, then a stray start and next word while busy, both ignored
	task op_case(input fpet_op_t op, input int n, input string name);
		int d0;
		d0 = n_done;
		pulse('{op, 1'b1, 1'b0, 1'b0});
		chk({name, " busy"}, 1'b1, busy);
		pulse('{FPET_OP_MASS, 1'b1, 1'b1, 1'b1});
		i_host.run(n - 1);
		settle();
		chk({name, " early"}, 1'b1, busy === 1'b1 && n_done == d0);
		i_host.run(1);
		settle();
		chk({name, " done"}, 1'b1, busy === 1'b0 && n_done == d0 + 1);
	endtask
	// Block of three words, last one flagged, then the end sequence
	task block_case();
		int w0, d0;
		w0 = n_wd;
		d0 = n_done;
		pulse('{FPET_OP_BLOCK, 1'b1, 1'b0, 1'b0});
		for (int k = 0; k < 3; k++) begin
			if (k > 0) pulse('{FPET_OP_NONE, 1'b0, 1'b1, k == 2});
			i_host.run(k == 0 ? 24 : 17);
			settle();
			chk("word early", 1'b1, n_wd == w0 + k);
			i_host.run(1);
			settle();
			chk("word done", 1'b1, n_wd == w0 + k + 1 && busy === 1'b1);
		end
		i_host.run(5);
		settle();
		chk("end early", 1'b1, n_done == d0 && busy === 1'b1);
		i_host.run(1);
		settle();
		chk("block done", 1'b1, n_done == d0 + 1 && busy === 1'b0);
	endtask
	// Sixty-four words with no last flag end at the top position
	task block_full_case();
		int w0, d0;
		w0 = n_wd;
		d0 = n_done;
		pulse('{FPET_OP_BLOCK, 1'b1, 1'b0, 1'b0});
		i_host.run(25);
		settle();
		for (int k = 1; k < 64; k++) begin
			pulse('{FPET_OP_NONE, 1'b0, 1'b1, 1'b0});
			i_host.run(18);
			settle();
		end
		chk("full block words", 1'b1, n_wd == w0 + 64 && n_done == d0 && busy === 1'b1);
		// A next word during the end sequence is refused
		pulse('{FPET_OP_NONE, 1'b0, 1'b1, 1'b0});
		i_host.run(5);
		settle();
		chk("full block end early", 1'b1, n_wd == w0 + 64 && n_done == d0 && busy === 1'b1);
		i_host.run(1);
		settle();
		chk("full block done", 1'b1, n_done == d0 + 1 && busy === 1'b0);
	endtask
	// Enable low freezes the count, so ticks meanwhile are not counted
	task ce_case();
		int d0;
		d0 = n_done;
		pulse('{FPET_OP_WORD, 1'b1, 1'b0, 1'b0});
		i_host.run(10);
		settle();
		ce = 1'b0;
		i_host.run(25);
		settle();
		chk("frozen busy", 1'b1, busy === 1'b1 && n_done == d0);
		ce = 1'b1;
		settle();
		i_host.run(19);
		settle();
		chk("thawed early", 1'b1, busy === 1'b1 && n_done == d0);
		i_host.run(1);
		settle();
		chk("thawed done", 1'b1, busy === 1'b0 && n_done == d0 + 1);
	endtask
	// Cuts a hang short
	initial begin
		#1000000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("idle after reset", 1'b0, busy);
		op_case(FPET_OP_WORD, 30, "word");
		// Blocks stay far below the total program time per block
		block_case();
		block_full_case();
		ce_case();
		op_case(FPET_OP_SEG, 4819, "seg");
		// With the clock in band one mass erase already reaches the total
		op_case(FPET_OP_MASS, 10593, "mass");
		end_of_test();
	end
endmodule
